// ==== common/rhp_pkg.sv ====
// Package: register indices, field layout and reset values of the root hub power block
package rhp_pkg;
    // Register indices (command codes); byte address is four times the index
    localparam logic [7:0] RHP_CHAR_RD_IDX = 8'h12;
    localparam logic [7:0] RHP_CHAR_WR_IDX = 8'h92;
    localparam logic [7:0] RHP_MASK_RD_IDX = 8'h13;
    localparam logic [7:0] RHP_MASK_WR_IDX = 8'h93;
    // Power command register of our own (not printed)
    localparam logic [7:0] RHP_CMD_IDX = 8'h40;
    localparam logic [7:0] RHP_STAT_IDX = 8'h41;
    // Field positions
    localparam int RHP_PORT_CNT_LSB = 0;
    localparam int RHP_MODE_SEL_BIT = 8;
    localparam int RHP_NO_SWITCH_BIT = 9;
    localparam int RHP_MASK_LSB = 16;
    localparam int RHP_REMOVABLE_LSB = 0;
    // Command register bits: global set/clear, per-port set/clear [port]
    localparam int RHP_CMD_GSET = 0;
    localparam int RHP_CMD_GCLR = 1;
    localparam int RHP_CMD_PSET_LSB = 4;
    localparam int RHP_CMD_PCLR_LSB = 8;
    // Reset values
    localparam logic [1:0] RHP_PORT_CNT_RST = 2'h2;
    localparam logic RHP_MODE_SEL_RST = 1'b1;
    localparam logic RHP_NO_SWITCH_RST = 1'b0;
    localparam logic [2:0] RHP_MASK_RST = 3'h0;
    localparam logic [2:0] RHP_REMOVABLE_RST = 3'h0;

    typedef struct packed {
        logic [9:0] addr;
        logic write;
        logic [31:0] wdata;
    } rhp_req_type;

    typedef struct packed {
        logic global_set;
        logic global_clr;
        logic [2:1] port_set;
        logic [2:1] port_clr;
    } rhp_cmd_type;
endpackage : rhp_pkg

// ==== hw/rhp_power_ctrl.sv ====
// Port power state machine driven by global and per-port commands
`timescale 1ns/100ps
`default_nettype none
module rhp_power_ctrl #(
    parameter int PORTS = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire logic no_power_switch,
    input wire logic power_switch_mode_sel,
    input wire logic [2:1] port_power_mask,
    // Commands
    input wire rhp_pkg::rhp_cmd_type cmd,
    input wire logic cmd_valid,
    // Port power
    output logic [2:1] port_power
);
    import rhp_pkg::*;

    initial begin
        if (PORTS != 2) $error("rhp_power_ctrl serves exactly two ports");
    end

    logic [2:1] next_port_power;
    logic [2:1] per_port;

    // Mask only matters in per-port mode
    assign per_port = power_switch_mode_sel ? port_power_mask : 2'h0;

    always_comb begin
        next_port_power = port_power;
        if (no_power_switch) begin
            next_port_power = 2'h3;
        end else if (cmd_valid) begin
            for (int p = 1; p <= 2; p++) begin
                if (per_port[p]) begin
                    if (cmd.port_set[p]) next_port_power[p] = 1'b1;
                    if (cmd.port_clr[p]) next_port_power[p] = 1'b0;
                end else begin
                    // unmasked ports move together on global
                    if (cmd.global_set) next_port_power[p] = 1'b1;
                    if (cmd.global_clr) next_port_power[p] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_power <= 2'h0;
        end else begin
            port_power <= next_port_power;
        end
    end

    // Global command in global mode powers both ports together in the next cycle
    a_global_ganged: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_valid && !no_power_switch && !power_switch_mode_sel
         && cmd.global_set && !cmd.global_clr) |=> port_power == 2'h3)
        else $error("global set did not power both ports");
    a_masked_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (!no_power_switch && power_switch_mode_sel && port_power_mask[1]
         && !(cmd_valid && (cmd.port_set[1] || cmd.port_clr[1])))
        |=> port_power[1] == $past(port_power[1]))
        else $error("masked port 1 changed without port command");
    a_unmasked_port: assert property (@(posedge pclk) disable iff (!presetn)
        (!no_power_switch && power_switch_mode_sel && !port_power_mask[2]
         && !(cmd_valid && (cmd.global_set || cmd.global_clr)))
        |=> port_power[2] == $past(port_power[2]))
        else $error("unmasked port 2 changed without global command");
    a_always_on: assert property (@(posedge pclk) disable iff (!presetn)
        no_power_switch |=> port_power == 2'h3)
        else $error("ports not powered with switching off");
endmodule : rhp_power_ctrl
`default_nettype wire

// ==== hw/rhp_root_hub.sv ====
// Root hub descriptor registers with APB slave and port power control
//
// How it works
// - The mode bit 8 only steers power while the no-switching bit is clear.
// - In global mode both ports switch power together in one cycle.
// - In per-port mode a masked port moves only on per-port commands.
// - In per-port mode an unmasked port follows only global commands.
// - Bits 1 to 0 report the port count, two at most.
// - The second descriptor reads at code 13H and writes at code 93H.
// - The port power mask sits in bits 18 to 16, bit 16 reserved.
// - The mask is ignored while the mode bit selects global switching.
// - Removable bits sit in bits 2 to 0, set means fixed, bit 0 reserved.
// - Every register moves as one full 32-bit word.
// - With no-switching set all ports stay powered.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module rhp_root_hub (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port power outputs
    output logic [2:1] port_power,
    output logic [2:1] port_fixed
);
    import rhp_pkg::*;

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic power_switch_mode_sel;
    logic no_power_switch;
    logic [2:1] port_power_mask;
    logic [2:1] device_removable_bits;
    logic [1:0] downstream_port_count;
    rhp_cmd_type cmd;
    logic cmd_valid;
    logic access;
    logic wr;
    logic [7:0] idx;
    logic [31:0] next_prdata;
    logic hit;

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign idx = paddr[9:2];
    assign pready = 1'b1;
    assign downstream_port_count = RHP_PORT_CNT_RST;
    assign port_fixed = device_removable_bits;

    // Decode an index, accepting either command code of a register
    function automatic logic is_reg(input logic [7:0] i,
                                    input logic [7:0] rd,
                                    input logic [7:0] wrc);
        is_reg = (i == rd) || (i == wrc);
    endfunction : is_reg

    // ---------------------------------------------------------------
    // Write path
    // ---------------------------------------------------------------
    // Partial-lane writes are refused: the words move whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_switch_mode_sel <= RHP_MODE_SEL_RST;
            no_power_switch <= RHP_NO_SWITCH_RST;
        end else if (wr && pstrb == 4'hf
                     && is_reg(idx, RHP_CHAR_RD_IDX, RHP_CHAR_WR_IDX)) begin
            power_switch_mode_sel <= pwdata[RHP_MODE_SEL_BIT];
            no_power_switch <= pwdata[RHP_NO_SWITCH_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_power_mask <= RHP_MASK_RST[2:1];
            device_removable_bits <= RHP_REMOVABLE_RST[2:1];
        end else if (wr && pstrb == 4'hf
                     && is_reg(idx, RHP_MASK_RD_IDX, RHP_MASK_WR_IDX)) begin
            // reserved bit 0 of each field is dropped
            port_power_mask <= pwdata[RHP_MASK_LSB+2 -: 2];
            device_removable_bits <= pwdata[RHP_REMOVABLE_LSB+2 -: 2];
        end
    end

    // Power commands are one-shot strobes from a write
    always_comb begin
        cmd.global_set = pwdata[RHP_CMD_GSET];
        cmd.global_clr = pwdata[RHP_CMD_GCLR];
        // Lowest bit of each pair drives port 1
        cmd.port_set = pwdata[RHP_CMD_PSET_LSB +: 2];
        cmd.port_clr = pwdata[RHP_CMD_PCLR_LSB +: 2];
    end

    // Registered so the power change lands one cycle after the write
    logic cmd_valid_q;
    rhp_cmd_type cmd_q;
    assign cmd_valid = wr && pstrb == 4'hf && idx == RHP_CMD_IDX;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            cmd_valid_q <= cmd_valid;
            cmd_q <= cmd;
        end
    end

    rhp_power_ctrl #(
        .PORTS(2)
    ) u_power (
        .pclk(pclk),
        .presetn(presetn),
        .no_power_switch(no_power_switch),
        .power_switch_mode_sel(power_switch_mode_sel),
        .port_power_mask(port_power_mask),
        .cmd(cmd_q),
        .cmd_valid(cmd_valid_q),
        .port_power(port_power)
    );

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    always_comb begin
        next_prdata = 32'h0000_0000;
        hit = 1'b1;
        if (is_reg(idx, RHP_CHAR_RD_IDX, RHP_CHAR_WR_IDX)) begin
            next_prdata[RHP_PORT_CNT_LSB +: 2] = downstream_port_count;
            next_prdata[RHP_MODE_SEL_BIT] = power_switch_mode_sel;
            next_prdata[RHP_NO_SWITCH_BIT] = no_power_switch;
        end else if (is_reg(idx, RHP_MASK_RD_IDX, RHP_MASK_WR_IDX)) begin
            next_prdata[RHP_MASK_LSB+2 -: 2] = port_power_mask;
            next_prdata[RHP_REMOVABLE_LSB+2 -: 2] = device_removable_bits;
        end else if (idx == RHP_STAT_IDX) begin
            next_prdata[2:1] = port_power;
        end else if (idx != RHP_CMD_IDX) begin
            hit = 1'b0;
        end
    end

    // Data output from a flip-flop, loaded in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Unmapped addresses and partial writes answer with an error
    assign pslverr = access && (!hit || (pwrite && pstrb != 4'hf) ||
                                (paddr[11:10] != 2'h0));

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[15:10] == 6'h00 && prdata[31:19] == 13'h0000
        && prdata[16] == 1'b0)
        else $error("reserved read bits not zero");
    a_port_count: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == RHP_CHAR_RD_IDX)
        |=> prdata[1:0] == 2'h2)
        else $error("port count not two");
    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && pstrb == 4'hf && idx == RHP_MASK_WR_IDX)
        |=> port_power_mask == $past(pwdata[18:17])
            && device_removable_bits == $past(pwdata[2:1]))
        else $error("mask register write lost");
    a_whole_word: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && pstrb != 4'hf) |=> $stable(port_power_mask)
            && $stable(power_switch_mode_sel))
        else $error("partial write changed a register");
endmodule : rhp_root_hub
`default_nettype wire

// ==== tb/rhp_root_hub_tb.sv ====
// Self-checking testbench of the root hub power descriptor block
`timescale 1ns/100ps
`default_nettype none
module rhp_root_hub_tb;
    import rhp_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [2:1] port_power, port_fixed;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #50 pclk = ~pclk;
    rhp_root_hub DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_power(port_power), .port_fixed(port_fixed));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] idx, output logic [31:0] r);
        logic e;
        apb(1'b0, idx, 32'h0, 4'hf, r, e);
    endtask : rd
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, 4'hf, r, e);
    endtask : wr
    // Power command, then port power two edges later
    task automatic pwr(input logic [31:0] c, input logic [2:1] e);
        wr(RHP_CMD_IDX, c);
        repeat (2) @(posedge pclk);
        #1;
        chk("port_power", {30'h0, port_power}, {30'h0, e});
    endtask : pwr
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        rd(RHP_CHAR_RD_IDX, r);
        chk("characteristics", r, 32'h00000102);
        rd(RHP_MASK_RD_IDX, r);
        chk("mask_removable", r, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fields;
        logic [31:0] r;
        logic e;
        wr(RHP_MASK_WR_IDX, 32'hffffffff);
        rd(RHP_MASK_RD_IDX, r);
        chk("mask_removable", r, 32'h00060006);
        chk("port_fixed", {30'h0, port_fixed}, 32'h3);
        apb(1'b1, RHP_MASK_WR_IDX, 32'h0, 4'h3, r, e);
        chk("partial strobe err", {31'h0, e}, 32'h1);
        rd(RHP_MASK_RD_IDX, r);
        chk("mask kept", r, 32'h00060006);
        apb(1'b0, 8'h20, 32'h0, 4'hf, r, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        $display("test fields done");
    endtask : t_fields
    task automatic t_per_port;
        wr(RHP_MASK_WR_IDX, 32'h00040000);
        pwr(32'h1, 2'b01);
        pwr(32'h20, 2'b11);
        pwr(32'h2, 2'b10);
        pwr(32'h10, 2'b10);
        pwr(32'h200, 2'b00);
        $display("test per port done");
    endtask : t_per_port
    task automatic t_global;
        wr(RHP_CHAR_WR_IDX, 32'h0);
        pwr(32'h1, 2'b11);
        pwr(32'h200, 2'b11);
        pwr(32'h2, 2'b00);
        $display("test global done");
    endtask : t_global
    task automatic t_always_on;
        logic [31:0] r;
        wr(RHP_CHAR_WR_IDX, 32'h00000300);
        pwr(32'h2, 2'b11);
        pwr(32'h300, 2'b11);
        rd(RHP_STAT_IDX, r);
        chk("status", r, 32'h6);
        $display("test always on done");
    endtask : t_always_on
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_per_port();
        t_global();
        t_always_on();
        summarize();
    end
endmodule : rhp_root_hub_tb
`default_nettype wire
